// file: logic/rmt_pkg.sv
// constants shared by the addressing and transmit control block
// assumes a 10 MHz clock and timing parameters in us
package rmt_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS = 1000000; // timer tick
	localparam int BACKOFF_US = 320; // one unit backoff period
	localparam int BACKOFF_CYCLES = (BACKOFF_US * 1000) / CLK_PERIOD_NS;
	localparam int ACK_WAIT_US = 1000; // wait for acknowledgment
	localparam int ACK_WAIT_CYC = (ACK_WAIT_US * 1000) / CLK_PERIOD_NS;
	localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
	localparam logic [15:0] ADDR_USE_LONG = 16'hFFFE;
	localparam logic [15:0] ADDR_DISABLED = 16'hFFFF;
	localparam logic [31:0] BCAST_LOW = 32'h0000FFFF;
	localparam logic [31:0] BCAST_HIGH = 32'h00000000;
	localparam logic [2:0] UNICAST_RETRIES = 3'h3;
	localparam logic [1:0] CCA_RETRIES = 2'h2;
	localparam logic [1:0] MAC_MODE_DEFAULT = 2'h0;
	localparam logic [2:0] MAX_BACKOFF_EXP = 3'h5;
	localparam int QUEUE_DEPTH = 2;
	localparam int A1_POLL_ON_PIN_BIT = 3;
	localparam logic [7:0] LFSR_SEED = 8'hA5;
	typedef enum logic [2:0] {
		RMT_IDLE, RMT_TX, RMT_RX, RMT_SLEEP, RMT_CMD
	} rmt_mode_t;
endpackage

// file: logic/rmt_backoff.sv
// random backoff delay before a clear channel assessment
// assumes start pulses one cycle, exponent stable while busy
`timescale 1ns/1ns
module rmt_backoff #(
	parameter int UNIT_CYCLES = rmt_pkg::BACKOFF_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic start, // begin a backoff
	input wire logic [2:0] exponent, // backoff exponent
	output logic done // pulse when delay ends
);
	logic [7:0] lfsr_reg;
	logic [7:0] slots_reg;
	logic [15:0] unit_reg;
	logic busy_reg;
	logic [7:0] mask;

	// free running pseudo random source
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			lfsr_reg <= rmt_pkg::LFSR_SEED;
		else
			lfsr_reg <= {lfsr_reg[6:0],
				lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
	end

	assign mask = 8'((16'h0001 << exponent) - 16'h0001);

	// count random number of whole backoff units
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
			slots_reg <= 8'h00;
			unit_reg <= 16'h0000;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				slots_reg <= lfsr_reg & mask;
				unit_reg <= 16'(UNIT_CYCLES - 1);
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (slots_reg == 8'h00) begin
					busy_reg <= 1'b0; // no slots left: delay ends
					done <= 1'b1;
				end else if (unit_reg == 16'h0000) begin
					slots_reg <= slots_reg - 8'h01;
					unit_reg <= 16'(UNIT_CYCLES - 1);
				end else
					unit_reg <= unit_reg - 16'h0001;
			end
		end
	end
endmodule // rmt_backoff

// file: logic/rmt_indirect_queue.sv
// coordinator store for indirect messages, two entries
// assumes tick is a one-cycle pulse once per millisecond
`timescale 1ns/1ns
module rmt_indirect_queue (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic tick, // millisecond tick
	input wire logic [15:0] hold_time, // lifetime in ticks
	input wire logic push, // hold a message
	input wire logic [63:0] push_dst, // its destination
	output logic full, // no free entry
	input wire logic request, // destination asks for data
	input wire logic [63:0] request_src, // requester address
	output logic release_valid, // pulse: send held message
	output logic [63:0] release_dst, // its destination
	output logic discard // pulse: message expired
);
	localparam int D = rmt_pkg::QUEUE_DEPTH;
	logic [D-1:0] used_reg;
	logic [63:0] dst_reg [D];
	logic [15:0] age_reg [D];
	logic [D-1:0] hit, expire, free;
	logic [D-1:0] take;

	always_comb begin
		take = '0;
		for (int i = 0; i < D; i++)
			if (free[i] && take == '0 && push)
				take[i] = 1'b1;
	end
	assign full = (free == '0);

	// one slot per entry: match, age and expiry
	genvar g;
	for (g = 0; g < D; g++) begin : slot
		assign free[g] = !used_reg[g];
		assign hit[g] = used_reg[g] && request && dst_reg[g] == request_src;
		assign expire[g] = used_reg[g] && tick && age_reg[g] >= hold_time;
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				used_reg[g] <= 1'b0;
				dst_reg[g] <= 64'h0;
				age_reg[g] <= 16'h0000;
			end else if (take[g]) begin
				used_reg[g] <= 1'b1;
				dst_reg[g] <= push_dst;
				age_reg[g] <= 16'h0000;
			end else if (hit[g] || expire[g]) begin
				used_reg[g] <= 1'b0;
			end else if (tick && used_reg[g])
				age_reg[g] <= age_reg[g] + 16'h0001;
		end
	end

	// hand one requested message back per cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			release_valid <= 1'b0;
			release_dst <= 64'h0;
			discard <= 1'b0;
		end else begin
			release_valid <= |hit;
			release_dst <= hit[0] ? dst_reg[0] : dst_reg[D-1];
			discard <= |expire;
		end
	end
endmodule // rmt_indirect_queue

// file: logic/rmt_tx_control.sv
// addressing, transmit and receive control of a wireless network node
// assumes all inputs come from logic on clk; parameters held stable
// Overview of operation
// - serial number is source when short disabled
// - short source address below FFFE used directly
// - destination short when high zero, low small
// - destination field is high and low concatenated
// - unicast accepted on own short address or own serial number
// - association sets short source to FFFE
// - unicast acknowledged, resent up to three times
// - broadcast destination accepted by every node
// - broadcast gets no acknowledgment or resend for lack of one
// - broadcast sent once or retries plus two
// - idle leaves for transmit, receive, sleep, command
// - only coordinator holds packets until requested
// - at most two held indirect messages
// - zero sleep period forces direct transmission
// - direct to awake device until inactivity expires
// - broadcast does not restart inactivity timer
// - held message discarded after sleep period
// - end device polls on wake and forced poll
// - withhold transmission when channel energy high
// - random backoff, zero exponent means none
// - failed channel assessment retried twice in default mac mode, for broadcast or zero retry count; else not retried
// - unacknowledged unicast records acknowledgment failure
`timescale 1ns/1ns
module rmt_tx_control #(
	parameter int MS_CYCLES = rmt_pkg::MS_CYC,
	parameter int ACK_WAIT_CYCLES = rmt_pkg::ACK_WAIT_CYC,
	parameter int BACKOFF_UNIT = rmt_pkg::BACKOFF_CYCLES
) (
	input wire logic clk, // 10 MHz clock
	input wire logic rst, // async reset, high
	input wire logic [15:0] short_source_address, // configured short addr
	input wire logic load_short_address, // pulse: load short addr
	input wire logic association_done, // pulse: end device associated
	input wire logic [31:0] factory_serial_low, // serial number low
	input wire logic [31:0] factory_serial_high, // serial number high
	input wire logic [31:0] destination_low, // destination low
	input wire logic [31:0] destination_high, // destination high
	input wire logic [7:0] retry_count, // broadcast repeat setting
	input wire logic [15:0] cyclic_sleep_period, // hold time, ms
	input wire logic [15:0] time_before_sleep, // inactivity time, ms
	input wire logic [7:0] clear_channel_threshold, // energy limit
	input wire logic [2:0] backoff_exponent, // minimum exponent
	input wire logic [1:0] mac_mode_select, // mac mode
	input wire logic [7:0] end_device_association_config, // assoc cfg
	input wire logic coordinator_enable, // node is coordinator
	input wire logic serial_input_buffer_ready, // packet waiting
	output logic tx_taken, // pulse: packet accepted
	output logic [1:0] tx_result, // 0 ok 1 cca fail or expired 2 ack fail 3 held
	output logic tx_result_valid, // pulse: result ready
	input wire logic sleep_condition, // sleep allowed
	input wire logic command_sequence, // pulse: command entry seen
	input wire logic command_exit, // pulse: leave command mode
	input wire logic wake_cyclic, // pulse: woke after sleep period
	input wire logic wake_pin, // pulse: woke by pin
	input wire logic forced_poll_command, // pulse: poll now
	input wire logic [7:0] channel_energy, // measured energy
	output logic frame_send, // pulse: send frame
	output logic frame_poll, // frame is a data request
	output logic [63:0] frame_src_addr, // source field
	output logic frame_src_long, // source is 64-bit
	output logic [63:0] frame_dst_addr, // destination field
	output logic frame_dst_long, // destination is 64-bit
	output logic frame_ack_request, // ask for acknowledgment
	input wire logic frame_sent, // pulse: frame on air
	input wire logic ack_received, // pulse: acknowledgment seen
	input wire logic rx_valid, // pulse: frame received
	input wire logic [63:0] rx_dst_addr, // received destination
	input wire logic rx_dst_long, // received destination 64-bit
	input wire logic [63:0] rx_src_addr, // received source
	input wire logic rx_data_request, // received frame is a poll
	output logic rx_accept, // pulse: frame accepted
	output logic ack_send, // pulse: send acknowledgment
	output logic ack_failure, // sticky until next transfer starts
	output rmt_pkg::rmt_mode_t mode // current operating mode
);
	typedef enum logic [2:0] {
		TX_IDLE, TX_BACKOFF, TX_CCA, TX_SEND, TX_WAIT_ACK
	} rmt_tx_state_t;

	rmt_tx_state_t tx_reg;
	logic [15:0] my_reg;
	logic [15:0] ms_reg;
	logic tick;
	logic [15:0] awake_timer_reg;
	logic [63:0] awake_addr_reg;
	logic awake_reg;
	logic [8:0] sends_reg, sends_max;
	logic [1:0] cca_reg;
	logic [2:0] be_reg;
	logic [15:0] ack_timer_reg;
	logic bo_start, bo_done;
	logic src_long, dst_long, dst_bcast, indirect;
	logic [63:0] dst_field, src_field;
	logic q_full, q_push, q_rel, q_discard;
	logic [63:0] q_rel_dst;
	logic poll_pend_reg, rel_pend_reg;
	logic [63:0] rel_dst_reg;
	logic rx_hit, rx_bcast;

	// own short address, overridden on association
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			my_reg <= rmt_pkg::ADDR_DISABLED;
		else if (association_done)
			my_reg <= rmt_pkg::ADDR_USE_LONG;
		else if (load_short_address)
			my_reg <= short_source_address;
	end

	// address fields of outgoing frames
	assign src_long = my_reg >= rmt_pkg::ADDR_USE_LONG;
	assign src_field = src_long ? {factory_serial_high, factory_serial_low}
		: {48'h0, my_reg};
	assign dst_field = {destination_high, destination_low};
	assign dst_long = !(destination_high == 32'h0 &&
		destination_low < {16'h0, rmt_pkg::ADDR_USE_LONG});
	assign dst_bcast = destination_high == rmt_pkg::BCAST_HIGH &&
		destination_low == rmt_pkg::BCAST_LOW;

	// millisecond tick for sleep and inactivity timers
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ms_reg <= 16'h0000;
		else if (tick)
			ms_reg <= 16'h0000;
		else
			ms_reg <= ms_reg + 16'h0001;
	end
	assign tick = ms_reg == 16'(MS_CYCLES - 1);

	// receive filter and acknowledgment
	assign rx_bcast = !rx_dst_long &&
		rx_dst_addr == {48'h0, rmt_pkg::ADDR_DISABLED};
	assign rx_hit = rx_bcast || (rx_dst_long ?
		rx_dst_addr == {factory_serial_high, factory_serial_low} :
		(!src_long && rx_dst_addr == {48'h0, my_reg}));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_accept <= 1'b0;
			ack_send <= 1'b0;
		end else begin
			rx_accept <= rx_valid && rx_hit && mode != rmt_pkg::RMT_SLEEP;
			ack_send <= rx_valid && rx_hit && !rx_bcast &&
				mode != rmt_pkg::RMT_SLEEP;
		end
	end

	// awake window of one end device, kept by the coordinator
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awake_reg <= 1'b0;
			awake_addr_reg <= 64'h0;
			awake_timer_reg <= 16'h0000;
		end else if (rx_valid && rx_hit && !rx_bcast) begin
			awake_reg <= 1'b1;
			awake_addr_reg <= rx_src_addr;
			awake_timer_reg <= time_before_sleep;
		end else if (frame_sent && !dst_bcast && awake_reg &&
			dst_field == awake_addr_reg && !frame_poll) begin
			awake_timer_reg <= time_before_sleep;
		end else if (tick && awake_reg) begin
			if (awake_timer_reg == 16'h0000)
				awake_reg <= 1'b0; // back to indirect
			else
				awake_timer_reg <= awake_timer_reg - 16'h0001;
		end
	end

	// indirect path: coordinator, nonzero period, device asleep
	assign indirect = coordinator_enable && !dst_bcast &&
		cyclic_sleep_period != 16'h0000 &&
		!(awake_reg && awake_addr_reg == dst_field);
	assign q_push = tx_reg == TX_IDLE && mode == rmt_pkg::RMT_IDLE &&
		serial_input_buffer_ready && indirect && !q_full;

	rmt_indirect_queue u_queue (
		.clk(clk),
		.rst(rst),
		.tick(tick),
		.hold_time(cyclic_sleep_period),
		.push(q_push),
		.push_dst(dst_field),
		.full(q_full),
		.request(rx_valid && rx_hit && rx_data_request &&
			coordinator_enable),
		.request_src(rx_src_addr),
		.release_valid(q_rel),
		.release_dst(q_rel_dst),
		.discard(q_discard)
	);

	// polls and released messages wait for the engine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			poll_pend_reg <= 1'b0;
			rel_pend_reg <= 1'b0;
			rel_dst_reg <= 64'h0;
		end else begin
			if (!coordinator_enable && (wake_cyclic || forced_poll_command ||
				(wake_pin && end_device_association_config[
				rmt_pkg::A1_POLL_ON_PIN_BIT])))
				poll_pend_reg <= 1'b1;
			else if (tx_reg == TX_IDLE && mode == rmt_pkg::RMT_IDLE &&
				!rel_pend_reg)
				poll_pend_reg <= 1'b0;
			if (q_rel) begin
				rel_pend_reg <= 1'b1;
				rel_dst_reg <= q_rel_dst;
			end else if (tx_reg == TX_IDLE && mode == rmt_pkg::RMT_IDLE)
				rel_pend_reg <= 1'b0;
		end
	end

	// operating mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			mode <= rmt_pkg::RMT_IDLE;
		else unique case (mode)
			rmt_pkg::RMT_IDLE: begin
				if (command_sequence)
					mode <= rmt_pkg::RMT_CMD;
				else if (rel_pend_reg || poll_pend_reg ||
					(serial_input_buffer_ready && !indirect))
					mode <= rmt_pkg::RMT_TX;
				else if (rx_valid && rx_hit)
					mode <= rmt_pkg::RMT_RX;
				else if (sleep_condition)
					mode <= rmt_pkg::RMT_SLEEP;
			end
			rmt_pkg::RMT_TX:
				if (tx_reg == TX_IDLE)
					mode <= rmt_pkg::RMT_IDLE;
			rmt_pkg::RMT_RX:
				mode <= rmt_pkg::RMT_IDLE;
			rmt_pkg::RMT_SLEEP:
				if (!sleep_condition || wake_pin || wake_cyclic)
					mode <= rmt_pkg::RMT_IDLE;
			rmt_pkg::RMT_CMD:
				if (command_exit)
					mode <= rmt_pkg::RMT_IDLE;
		endcase
	end

	// a transfer starts from idle
	assign bo_start = mode == rmt_pkg::RMT_IDLE && tx_reg == TX_IDLE &&
		!command_sequence && (rel_pend_reg || poll_pend_reg ||
		(serial_input_buffer_ready && !indirect));

	rmt_backoff #(.UNIT_CYCLES(BACKOFF_UNIT)) u_backoff (
		.clk(clk),
		.rst(rst),
		.start(bo_start || (tx_reg == TX_CCA &&
			channel_energy > clear_channel_threshold && cca_reg != 2'h0) ||
			(tx_reg == TX_WAIT_ACK && (ack_timer_reg == 16'h0000) &&
			!ack_received && sends_reg < sends_max)),
		.exponent(bo_start ? backoff_exponent : be_reg),
		.done(bo_done)
	);

	// number of transmissions allowed for this packet
	assign sends_max = frame_ack_request ?
		9'(rmt_pkg::UNICAST_RETRIES) + 9'h001 :
		(retry_count == 8'h00 ? 9'h001 :
		{1'b0, retry_count} + 9'h002);

	// transmit engine: backoff, assessment, send, acknowledgment
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_reg <= TX_IDLE;
			sends_reg <= 9'h000;
			cca_reg <= 2'h0;
			be_reg <= 3'h0;
			ack_timer_reg <= 16'h0000;
			frame_send <= 1'b0;
			frame_poll <= 1'b0;
			frame_src_addr <= 64'h0;
			frame_src_long <= 1'b0;
			frame_dst_addr <= 64'h0;
			frame_dst_long <= 1'b0;
			frame_ack_request <= 1'b0;
			tx_taken <= 1'b0;
			tx_result <= 2'h0;
			tx_result_valid <= 1'b0;
			ack_failure <= 1'b0;
		end else begin
			frame_send <= 1'b0;
			tx_taken <= q_push;
			tx_result_valid <= q_push || q_discard;
			if (q_push || q_discard)
				tx_result <= q_push ? 2'h3 : 2'h1;
			unique case (tx_reg)
				TX_IDLE:
					if (bo_start) begin
						tx_reg <= TX_BACKOFF;
						sends_reg <= 9'h000;
						cca_reg <= (mac_mode_select == rmt_pkg::MAC_MODE_DEFAULT ||
							dst_bcast || retry_count == 8'h00) ?
							rmt_pkg::CCA_RETRIES : 2'h0;
						be_reg <= backoff_exponent;
						ack_failure <= 1'b0;
						frame_poll <= !rel_pend_reg && poll_pend_reg;
						frame_src_addr <= src_field;
						frame_src_long <= src_long;
						frame_dst_addr <= rel_pend_reg ? rel_dst_reg : dst_field;
						frame_dst_long <= rel_pend_reg ? 1'b1 : dst_long;
						frame_ack_request <= rel_pend_reg || !dst_bcast;
						tx_taken <= !rel_pend_reg && !poll_pend_reg;
					end
				TX_BACKOFF:
					if (bo_done)
						tx_reg <= TX_CCA;
				TX_CCA:
					if (channel_energy > clear_channel_threshold) begin
						if (cca_reg == 2'h0) begin
							tx_reg <= TX_IDLE;
							tx_result <= 2'h1;
							tx_result_valid <= 1'b1;
						end else begin
							cca_reg <= cca_reg - 2'h1;
							if (be_reg < rmt_pkg::MAX_BACKOFF_EXP)
								be_reg <= be_reg + 3'h1;
							tx_reg <= TX_BACKOFF;
						end
					end else begin
						frame_send <= 1'b1;
						sends_reg <= sends_reg + 9'h001;
						tx_reg <= TX_SEND;
					end
				TX_SEND:
					if (frame_sent) begin
						ack_timer_reg <= 16'(ACK_WAIT_CYCLES - 1);
						if (frame_ack_request)
							tx_reg <= TX_WAIT_ACK;
						else if (sends_reg < sends_max)
							tx_reg <= TX_CCA;
						else begin
							tx_reg <= TX_IDLE;
							tx_result <= 2'h0;
							tx_result_valid <= 1'b1;
						end
					end
				TX_WAIT_ACK:
					if (ack_received) begin
						tx_reg <= TX_IDLE;
						tx_result <= 2'h0;
						tx_result_valid <= 1'b1;
					end else if (ack_timer_reg != 16'h0000)
						ack_timer_reg <= ack_timer_reg - 16'h0001;
					else if (sends_reg < sends_max)
						tx_reg <= TX_BACKOFF;
					else begin
						tx_reg <= TX_IDLE;
						ack_failure <= 1'b1;
						tx_result <= 2'h2;
						tx_result_valid <= 1'b1;
					end
			endcase
		end
	end
endmodule // rmt_tx_control

// file: test/rmt_chk.sv
// port checker for the transmit control block
// assumes a bind into rmt_tx_control by port name
`timescale 1ns/1ns
module rmt_chk (
	input logic clk, // clock
	input logic rst, // reset
	input logic [31:0] factory_serial_low, // serial
	input logic [31:0] factory_serial_high, // serial
	input logic [31:0] destination_low, // destination
	input logic [31:0] destination_high, // destination
	input logic [7:0] clear_channel_threshold, // limit
	input logic [2:0] backoff_exponent, // exponent
	input logic coordinator_enable, // role
	input logic [7:0] channel_energy, // energy
	input logic rx_valid, // rx strobe
	input logic [63:0] rx_dst_addr, // rx destination
	input logic rx_dst_long, // rx long
	input logic tx_taken, // taken
	input logic [1:0] tx_result, // result
	input logic tx_result_valid, // result strobe
	input logic frame_send, // frame start
	input logic frame_poll, // poll frame
	input logic [63:0] frame_src_addr, // source
	input logic frame_src_long, // source long
	input logic [63:0] frame_dst_addr, // destination
	input logic frame_dst_long, // destination long
	input logic frame_ack_request, // ack wanted
	input logic rx_accept, // accepted
	input logic ack_send, // ack out
	input logic ack_failure // ack failure
);
	logic bc, dd;
	// broadcast target, and a data frame of an end device
	assign bc = destination_high == rmt_pkg::BCAST_HIGH &&
		destination_low == rmt_pkg::BCAST_LOW;
	assign dd = frame_send && !frame_poll && !coordinator_enable;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	src_long_a: assert property (frame_send && frame_src_long
		|-> frame_src_addr == {factory_serial_high, factory_serial_low})
		else $error("long source field wrong");
	src_short_a: assert property (frame_send && !frame_src_long
		|-> frame_src_addr[63:16] == 48'h0 && frame_src_addr[15:0] < 16'hFFFE)
		else $error("short source field wrong");
	dst_short_a: assert property (dd && destination_high == 32'h0
		&& destination_low < 32'h0000FFFE |-> !frame_dst_long)
		else $error("short destination sent long");
	dst_concat_a: assert property (dd
		|-> frame_dst_addr == {destination_high, destination_low})
		else $error("destination field wrong");
	bcast_noack_a: assert property (dd && bc |-> !frame_ack_request)
		else $error("broadcast asks for ack");
	ucast_ack_a: assert property (dd && !bc |-> frame_ack_request)
		else $error("unicast without ack request");
	rx_bcast_a: assert property (rx_valid && !rx_dst_long
		&& rx_dst_addr == 64'hFFFF |=> rx_accept && !ack_send)
		else $error("broadcast receive wrong");
	rx_ack_a: assert property (ack_send
		|-> rx_accept && ($past(rx_dst_long) || $past(rx_dst_addr) != 64'hFFFF))
		else $error("ack without unicast accept");
	cca_ok_a: assert property (frame_send
		|-> $past(channel_energy) <= $past(clear_channel_threshold))
		else $error("sent on a busy channel");
	no_backoff_a: assert property (tx_taken && backoff_exponent == 3'h0
		&& !coordinator_enable && channel_energy <= clear_channel_threshold
		|-> ##[1:6] frame_send) else $error("late first send");
	ack_fail_a: assert property ($rose(ack_failure)
		|-> tx_result_valid && tx_result == 2'h2)
		else $error("ack failure without result");
endmodule // rmt_chk

// file: test/rmt_peer_node.sv
// peer radio node on the far side of the air interface
// assumes frame_send pulses once per frame, fields held meanwhile
`timescale 1ns/1ns
module rmt_peer_node (
	input logic clk, // clock
	input logic rst, // reset
	input logic frame_send, // frame start
	input logic frame_ack_request, // ack wanted
	input logic ack_enable, // peer answers
	input logic [3:0] air_delay, // cycles on air
	output logic frame_sent, // frame done
	output logic ack_received // ack back
);
	logic [4:0] air_cnt, ack_cnt;
	logic want_ack;
	// air time, then an ack only where one was asked for
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			air_cnt <= 5'h0;
			ack_cnt <= 5'h0;
			want_ack <= 1'b0;
		end else begin
			if (frame_send) begin
				air_cnt <= {1'b0, air_delay} + 5'h1;
				want_ack <= frame_ack_request && ack_enable;
			end else if (air_cnt != 5'h0)
				air_cnt <= air_cnt - 5'h1;
			if (air_cnt == 5'h1 && want_ack)
				ack_cnt <= {1'b0, air_delay} + 5'h2;
			else if (ack_cnt != 5'h0)
				ack_cnt <= ack_cnt - 5'h1;
		end
	end
	// strobes fall out of the counters
	assign frame_sent = air_cnt == 5'h1;
	assign ack_received = ack_cnt == 5'h1;
endmodule // rmt_peer_node

// file: test/tb.sv
// self-checking bench for the transmit control block
// assumes the peer node model and the bound port checker
`timescale 1ns/1ns
module tb;
	logic clk, rst, load_short_address, association_done, coordinator_enable;
	logic serial_input_buffer_ready, sleep_condition, command_sequence;
	logic command_exit, wake_cyclic, wake_pin, forced_poll_command, rx_valid;
	logic rx_dst_long, rx_data_request, ack_enable, frame_sent, ack_received;
	logic tx_taken, tx_result_valid, frame_send, frame_poll, frame_src_long;
	logic frame_dst_long, frame_ack_request, rx_accept, ack_send, ack_failure;
	logic [1:0] tx_result, mac_mode_select;
	logic [2:0] backoff_exponent;
	logic [3:0] air_delay;
	logic [7:0] retry_count, clear_channel_threshold, channel_energy;
	logic [7:0] end_device_association_config;
	logic [15:0] short_source_address, cyclic_sleep_period, time_before_sleep;
	logic [15:0] own;
	logic [31:0] factory_serial_low, factory_serial_high;
	logic [31:0] destination_low, destination_high;
	logic [63:0] frame_src_addr, frame_dst_addr, rx_dst_addr, rx_src_addr;
	logic [63:0] serial;
	rmt_pkg::rmt_mode_t mode;
	int fails = 0, checked = 0, sends = 0, cycles = 0;
	rmt_tx_control #(.MS_CYCLES(10), .ACK_WAIT_CYCLES(20),
		.BACKOFF_UNIT(4)) uut (.*);
	rmt_peer_node peer (.*);
	// clock
	always #50 clk = ~clk;
	// frame counter and run limit
	always @(posedge clk) begin
		cycles++;
		if (frame_send === 1'b1) sends++;
		if (cycles == 20000) begin
			fails++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(string what, logic [63:0] got, logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	function automatic int bcast_sends(logic [7:0] rr);
		return (rr == 8'h0) ? 1 : int'(rr) + 2;
	endfunction
	// one packet: hand over, await result, count frames
	task automatic send_pkt(logic [1:0] er, int en);
		sends = 0;
		serial_input_buffer_ready = 1'b1;
		while (tx_taken !== 1'b1) step(1);
		serial_input_buffer_ready = 1'b0;
		while (tx_result_valid !== 1'b1) step(1);
		check("tx result", 64'(tx_result), 64'(er));
		step(2);
		check("frames", 64'(sends), 64'(en));
	endtask
	// one received frame; exp is {accept, ack}
	task automatic rx_frame(logic [63:0] dst, logic lng, logic [1:0] exp);
		rx_dst_addr = dst;
		rx_dst_long = lng;
		rx_valid = 1'b1;
		step(1);
		rx_valid = 1'b0;
		rx_dst_addr = ~dst;
		check("rx accept ack", 64'({rx_accept, ack_send}), 64'(exp));
		step(1);
	endtask
	// main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{load_short_address, association_done, coordinator_enable,
			serial_input_buffer_ready, sleep_condition, command_sequence,
			command_exit, wake_cyclic, wake_pin, forced_poll_command, rx_valid,
			rx_dst_long, rx_data_request, mac_mode_select, backoff_exponent,
			retry_count, cyclic_sleep_period,
			destination_high, rx_dst_addr, rx_src_addr} = '0;
		void'($urandom(82042));
		factory_serial_low = $urandom;
		factory_serial_high = $urandom | 32'h1;
		serial = {factory_serial_high, factory_serial_low};
		short_source_address = 16'hFFFF;
		channel_energy = 8'h10;
		clear_channel_threshold = 8'h40;
		time_before_sleep = 16'h0014;
		end_device_association_config = 8'h08;
		ack_enable = 1'b1;
		air_delay = 4'($urandom_range(1, 6));
		destination_low = 32'h2;
		repeat (6) @(posedge clk);
		#5;
		rst = 1'b0;
		send_pkt(2'h0, 1);
		check("src long", frame_src_long, 1'h1);
		check("src", frame_src_addr, serial);
		check("dst long", frame_dst_long, 1'h0);
		$display("test long source done");
		own = 16'($urandom_range(0, 16'hFFFD));
		short_source_address = own;
		load_short_address = 1'b1;
		step(1);
		load_short_address = 1'b0;
		destination_high = $urandom | 32'h1;
		destination_low = $urandom;
		ack_enable = 1'b0;
		send_pkt(2'h2, 1 + 3);
		check("ack failure", ack_failure, 1'h1);
		check("src", frame_src_addr, {48'h0, own});
		check("dst", frame_dst_addr, {destination_high, destination_low});
		ack_enable = 1'b1;
		air_delay = 4'($urandom_range(1, 9));
		backoff_exponent = 3'($urandom_range(1, 2));
		send_pkt(2'h0, 1);
		check("ack failure", ack_failure, 1'h0);
		backoff_exponent = 3'h0;
		$display("test unicast done");
		destination_high = 32'h0;
		destination_low = 32'h0000FFFF;
		for (int i = 0; i < 3; i++) begin
			retry_count = (i == 0) ? 8'h0 : 8'($urandom_range(1, 4));
			send_pkt(2'h0, bcast_sends(retry_count));
			check("ack request", frame_ack_request, 1'h0);
		end
		$display("test broadcast done");
		destination_low = {16'h0, own ^ 16'h1};
		channel_energy = clear_channel_threshold + 8'h1;
		send_pkt(2'h1, 0);
		channel_energy = clear_channel_threshold;
		send_pkt(2'h0, 1);
		check("dst", frame_dst_addr, {32'h0, destination_low});
		$display("test channel done");
		rx_frame({48'h0, own}, 1'b0, 2'h3);
		rx_frame({48'h0, own ^ 16'h1}, 1'b0, 2'h0);
		rx_frame(64'hFFFF, 1'b0, 2'h2);
		rx_frame(serial, 1'b1, 2'h3);
		association_done = 1'b1;
		step(1);
		association_done = 1'b0;
		send_pkt(2'h0, 1);
		check("src long", frame_src_long, 1'h1);
		rx_frame({48'h0, own}, 1'b0, 2'h0);
		$display("test receive done");
		command_sequence = 1'b1;
		step(1);
		command_sequence = 1'b0;
		step(1);
		check("mode", mode, rmt_pkg::RMT_CMD);
		command_exit = 1'b1;
		step(1);
		command_exit = 1'b0;
		step(2);
		check("mode", mode, rmt_pkg::RMT_IDLE);
		for (int i = 0; i < 3; i++) begin
			forced_poll_command = i == 0;
			wake_cyclic = i == 1;
			wake_pin = i == 2;
			step(1);
			{forced_poll_command, wake_cyclic, wake_pin} = 3'h0;
			while (frame_send !== 1'b1) step(1);
			check("poll", frame_poll, 1'h1);
			step(200);
		end
		$display("test modes done");
		coordinator_enable = 1'b1;
		destination_high = $urandom | 32'h1;
		send_pkt(2'h0, 1);
		cyclic_sleep_period = 16'h0003;
		send_pkt(2'h3, 0);
		rx_src_addr = {destination_high, destination_low};
		rx_data_request = 1'b1;
		rx_frame(serial, 1'b1, 2'h3);
		rx_data_request = 1'b0;
		while (frame_send !== 1'b1) step(1);
		check("release dst", frame_dst_addr, rx_src_addr);
		step(60);
		send_pkt(2'h0, 1);
		step(250);
		send_pkt(2'h3, 0);
		while (tx_result_valid !== 1'b1) step(1);
		check("discard", tx_result, 2'h1);
		$display("test coordinator done");
		final_report();
	end
endmodule // tb
bind rmt_tx_control rmt_chk u_chk (.*);
